// ### rtl/usb_ifm_ctrl_pkg.sv
/*
 * Constants shared by the USB interface machine control block: register
 * offsets, field positions, reset values and packet codes.
 * Assumes a 32-bit peripheral access port clocked by the system clock.
 */
package usb_ifm_ctrl_pkg;

	// ******************************************************************
	// Peripheral identity and register offsets
	// ******************************************************************
	localparam logic [7:0] PERIPH_NUMBER      = 8'h01;
	localparam logic [7:0] OFS_SOFT_RESET     = 8'h00;
	localparam logic [7:0] OFS_IFM_CONTROL    = 8'h04;
	localparam logic [7:0] OFS_DEVICE_ADDRESS = 8'h08;
	localparam logic [7:0] OFS_FUNC_CONTROL   = 8'h0c;
	localparam logic [7:0] OFS_OTG_CONTROL    = 8'h10;
	localparam logic [7:0] OFS_OTG_FLAGS      = 8'h14;
	localparam logic [7:0] OFS_SERIAL_CONTROL = 8'h18;
	localparam logic [7:0] OFS_SIGNAL_FLAGS   = 8'h1c;
	localparam logic [7:0] OFS_STICKY_SELECT  = 8'h20;
	localparam logic [7:0] OFS_PORT_MASKS     = 8'h24;
	localparam logic [7:0] OFS_FRAME_NUMBER   = 8'h28;
	localparam logic [7:0] OFS_RX_PID         = 8'h2c;
	localparam logic [7:0] OFS_RX_ENDPOINT    = 8'h30;
	localparam logic [7:0] OFS_EP_MATCH       = 8'h34;
	localparam logic [7:0] OFS_OTG_FLAG_MASK  = 8'h38;
	localparam logic [7:0] OFS_POWER_SIGNAL   = 8'h3c;
	localparam logic [7:0] OFS_PHY_CONTROL    = 8'h40;

	// ******************************************************************
	// Field positions
	// ******************************************************************
	localparam int BIT_TOKEN_PROC   = 0;
	localparam int BIT_TOKEN_CHECK  = 1;
	localparam int BIT_LINESTATE    = 2;
	localparam int BIT_TIMING_MODE  = 4;
	localparam int BIT_POWER_SIGNAL = 5;
	localparam int BIT_SOF_TOKEN    = 6;
	localparam int BIT_EVENT_ACK    = 7;
	localparam int BIT_XCVR_SELECT  = 0;
	localparam int BIT_TERM_SELECT  = 1;
	localparam int OPMODE_LSB       = 2;

	// ******************************************************************
	// Writable masks and reset values
	// ******************************************************************
	localparam logic [7:0] CONTROL_WR_MASK = 8'hf7;
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	localparam logic [6:0] ADDRESS_RESET   = 7'h00;
	localparam logic [4:0] FUNC_RESET      = 5'h07;
	localparam logic [31:0] AUX_RESET      = 32'h0000_0000;
	localparam int AUX_COUNT = 10;

	// Start-of-frame packet identifier, low nibble
	localparam logic [3:0] PID_SOF = 4'h5;

endpackage : usb_ifm_ctrl_pkg

// ### rtl/aux_reg_if.sv
/*
 * Carrier between the control block and its word store for the
 * general-purpose control registers.
 * Assumes the host side drives one write strobe per accepted access.
 */
interface aux_reg_if;
	logic        wr;    // Write strobe, one cycle
	logic [3:0]  idx;   // Register slot
	logic [31:0] wdata; // Write data
	logic [31:0] rdata; // Read data of slot idx

	modport host (output wr, output idx, output wdata, input rdata);
	modport bank (input wr, input idx, input wdata, output rdata);
endinterface : aux_reg_if

// ### rtl/aux_reg_bank.sv
/*
 * Flip-flop store for the general-purpose read/write control words.
 * Assumes slot indices beyond the count are never written.
 */
module aux_reg_bank
	import usb_ifm_ctrl_pkg::*;
#(
	parameter int COUNT = AUX_COUNT
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	aux_reg_if.bank   port
);
	// ******************************************************************
	// Storage
	// ******************************************************************
	logic [31:0] word [COUNT]; // One word per slot

	// Read indexes the store; slots beyond the count answer zero
	assign port.rdata = (32'(port.idx) < COUNT) ? word[port.idx] : '0;

	// Write the addressed slot when enabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < COUNT; i++) word[i] <= AUX_RESET;
		end else if (ce && port.wr) begin
			word[port.idx] <= port.wdata;
		end
	end
endmodule : aux_reg_bank

// ### rtl/token_filter.sv
/*
 * Received-token filter of the interface state machine.
 * Assumes token fields arrive together with a one-cycle valid strobe.
 */
module token_filter
	import usb_ifm_ctrl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       soft_clr,  // Soft reset of machine state
	input  wire logic       proc_en,   // Token processing enable
	input  wire logic       check_en,  // Token check enable
	input  wire logic       sof_en,    // Frame start treated as token
	input  wire logic [6:0] dev_addr,  // Stored device address
	input  wire logic       tok_valid,
	input  wire logic [7:0] tok_pid,
	input  wire logic [6:0] tok_addr,
	input  wire logic [3:0] tok_endp,
	output logic            pass,      // Token forwarded, one cycle
	output logic [3:0]      last_pid,  // Last forwarded identifier
	output logic [3:0]      last_endp  // Last forwarded endpoint
);
	// ******************************************************************
	// Acceptance
	// ******************************************************************
	wire pid_ok  = !check_en || (tok_pid[3:0] == ~tok_pid[7:4]);
	wire is_sof  = (tok_pid[3:0] == PID_SOF);
	wire addr_ok = !is_sof && (tok_addr == dev_addr);
	wire sof_ok  = is_sof && sof_en;
	wire accept  = tok_valid && proc_en && pid_ok && (addr_ok || sof_ok);

	// Capture on acceptance; soft reset wins over a token in flight
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pass      <= 1'b0;
			last_pid  <= 4'h0;
			last_endp <= 4'h0;
		end else if (ce) begin
			pass <= accept && !soft_clr;
			if (soft_clr) begin
				last_pid  <= 4'h0;
				last_endp <= 4'h0;
			end else if (accept) begin
				last_pid  <= tok_pid[3:0];
				last_endp <= tok_endp;
			end
		end
	end
endmodule : token_filter

// ### rtl/usb_ifm_ctrl.sv
/*
 * Control block of the USB interface state machine: register map on the
 * peripheral port, soft reset, mode enables, address filter and the
 * transceiver mode selects.
 * Assumes requests are synchronous to clk and at most one per cycle.
 */

// Contract
// - Peripheral 1, full 32-bit accesses only
// - Any write at zero resets machine state
// - Control bit 0 enables token processing
// - Control bit 1 enables token checking
// - Control bit 2 enables line-state decoder
// - Bit 4 enables timing; bit 3 reserved
// - Control bit 5 enables power signalling
// - Bit 6 treats frame start as token
// - Bit 7 event acknowledge; upper bits reserved
// - Seven-bit address; pass only matching packets; with bit 6 set, frame starts pass on any address
// - Opmode field bits 4:2, reset one
// - Bit 1 drives termination select
// - Bit 0 drives transceiver select
module usb_ifm_ctrl
	import usb_ifm_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        acc_valid,
	input  wire logic        acc_write,
	input  wire logic [7:0]  acc_periph,
	input  wire logic        acc_word,
	input  wire logic [7:0]  acc_addr,
	input  wire logic [31:0] acc_wdata,
	output logic             acc_ack,
	output logic             acc_err,
	output logic [31:0]      acc_rdata,
	input  wire logic [5:0]  otg_flags,
	input  wire logic        tok_valid,
	input  wire logic [7:0]  tok_pid,
	input  wire logic [6:0]  tok_addr,
	input  wire logic [3:0]  tok_endp,
	output logic             tok_pass,
	output logic [3:0]       tok_pass_pid,
	output logic [3:0]       tok_pass_endp,
	output logic             soft_reset_pulse,
	output logic             token_processing_enable,
	output logic             token_check_enable,
	output logic             linestate_decoder_enable,
	output logic             timing_mode_enable,
	output logic             power_signalling_enable,
	output logic             frame_start_as_token,
	output logic             event_acknowledge_mode,
	output logic [2:0]       opmode,
	output logic             opmode_enable,
	output logic             termselect,
	output logic             xcvrselect
);

	// ******************************************************************
	// Decode helpers
	// ******************************************************************

	// Slot of a general-purpose register, or all ones when none
	function automatic logic [3:0] aux_slot(input logic [7:0] a);
		logic [3:0] s;
		s = 4'hf;
		if (a == OFS_OTG_CONTROL) s = 4'h0;
		else if (a == OFS_SERIAL_CONTROL) s = 4'h1;
		else if (a == OFS_SIGNAL_FLAGS) s = 4'h2;
		else if (a == OFS_STICKY_SELECT) s = 4'h3;
		else if (a == OFS_PORT_MASKS) s = 4'h4;
		else if (a == OFS_FRAME_NUMBER) s = 4'h5;
		else if (a == OFS_EP_MATCH) s = 4'h6;
		else if (a == OFS_OTG_FLAG_MASK) s = 4'h7;
		else if (a == OFS_POWER_SIGNAL) s = 4'h8;
		else if (a == OFS_PHY_CONTROL) s = 4'h9;
		return s;
	endfunction : aux_slot

	// ******************************************************************
	// State
	// ******************************************************************
	logic [7:0]  ctrl;       // Interface machine control bits
	logic [6:0]  dev_addr;   // Enumerated device address
	logic [4:0]  func;       // Opmode, termination, transceiver
	logic [31:0] next_rdata; // Read data for the answer

	aux_reg_if aux ();

	// ******************************************************************
	// Access qualification and address decode
	// ******************************************************************

	// Only full-word accesses to our peripheral number are taken
	wire for_us    = acc_valid && (acc_periph == PERIPH_NUMBER);
	wire acc_ok    = for_us && acc_word;
	wire acc_bad   = for_us && !acc_word;
	wire wr_ok     = acc_ok && acc_write;
	wire rd_ok     = acc_ok && !acc_write;

	wire hit_reset = (acc_addr == OFS_SOFT_RESET);
	wire hit_ctrl  = (acc_addr == OFS_IFM_CONTROL);
	wire hit_addr  = (acc_addr == OFS_DEVICE_ADDRESS);
	wire hit_func  = (acc_addr == OFS_FUNC_CONTROL);
	wire hit_otgf  = (acc_addr == OFS_OTG_FLAGS);
	wire hit_pid   = (acc_addr == OFS_RX_PID);
	wire hit_endp  = (acc_addr == OFS_RX_ENDPOINT);
	wire [3:0] slot = aux_slot(acc_addr);
	wire hit_aux   = (slot != 4'hf);

	// Soft reset fires on any data; the selects stay put
	wire soft_clr  = wr_ok && hit_reset;

	// Read-only and unmapped offsets have no write strobe at all
	wire wr_ctrl   = wr_ok && hit_ctrl;
	wire wr_addr   = wr_ok && hit_addr;
	wire wr_func   = wr_ok && hit_func;

	// ******************************************************************
	// Read data selection
	// ******************************************************************

	// Reserved bits and unmapped offsets answer zero
	assign next_rdata =
		!rd_ok   ? 32'h0000_0000 :
		hit_ctrl ? {24'h0000_00, ctrl} :
		hit_addr ? {25'h000_0000, dev_addr} :
		hit_func ? {27'h000_0000, func} :
		hit_otgf ? {26'h000_0000, otg_flags} :
		hit_pid  ? {28'h000_0000, tok_pass_pid} :
		hit_endp ? {28'h000_0000, tok_pass_endp} :
		hit_aux  ? aux.rdata : 32'h0000_0000;

	// ******************************************************************
	// General-purpose register store
	// ******************************************************************
	assign aux.wr    = wr_ok && hit_aux;
	assign aux.idx   = slot;
	assign aux.wdata = acc_wdata;

	aux_reg_bank #(
		.COUNT (AUX_COUNT)
	) u_bank (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.port  (aux.bank)
	);

	// ******************************************************************
	// Token filter
	// ******************************************************************
	token_filter u_filter (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.soft_clr  (soft_clr),
		.proc_en   (token_processing_enable),
		.check_en  (token_check_enable),
		.sof_en    (frame_start_as_token),
		.dev_addr  (dev_addr),
		.tok_valid (tok_valid),
		.tok_pid   (tok_pid),
		.tok_addr  (tok_addr),
		.tok_endp  (tok_endp),
		.pass      (tok_pass),
		.last_pid  (tok_pass_pid),
		.last_endp (tok_pass_endp)
	);

	// ******************************************************************
	// Registers
	// ******************************************************************

	// Control word; reserved bit 3 and upper bits never take data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CONTROL_RESET;
		end else if (ce && wr_ctrl) begin
			ctrl <= acc_wdata[7:0] & CONTROL_WR_MASK;
		end
	end

	// Device address; software leaves it at zero until enumerated
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dev_addr <= ADDRESS_RESET;
		end else if (ce && wr_addr) begin
			dev_addr <= acc_wdata[6:0];
		end
	end

	// Transceiver selects; untouched by soft reset so the phy stays up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			func <= FUNC_RESET;
		end else if (ce && wr_func) begin
			func <= acc_wdata[4:0];
		end
	end

	// Answer: one registered beat per request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ack   <= 1'b0;
			acc_err   <= 1'b0;
			acc_rdata <= 32'h0000_0000;
		end else if (ce) begin
			acc_ack   <= acc_ok;
			acc_err   <= acc_bad;
			acc_rdata <= next_rdata;
		end
	end

	// Soft reset strobe toward the rest of the machine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_pulse <= 1'b0;
		end else if (ce) begin
			soft_reset_pulse <= soft_clr;
		end
	end

	// ******************************************************************
	// Mode outputs
	// ******************************************************************
	assign token_processing_enable  = ctrl[BIT_TOKEN_PROC];
	assign token_check_enable       = ctrl[BIT_TOKEN_CHECK];
	assign linestate_decoder_enable = ctrl[BIT_LINESTATE];
	assign timing_mode_enable       = ctrl[BIT_TIMING_MODE];
	assign power_signalling_enable  = ctrl[BIT_POWER_SIGNAL];
	assign frame_start_as_token     = ctrl[BIT_SOF_TOKEN];
	assign event_acknowledge_mode   = ctrl[BIT_EVENT_ACK];

	// Opmode zero means the operating-mode drive is off
	assign opmode        = func[OPMODE_LSB +: 3];
	assign opmode_enable = (opmode != 3'h0);
	assign termselect    = func[BIT_TERM_SELECT];
	assign xcvrselect    = func[BIT_XCVR_SELECT];

	// ******************************************************************
	// Assertions
	// ******************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_word_ack: assert property (
		ce && acc_ok |=> acc_ack && !acc_err)
		else $error("accepted access not acknowledged");

	a_narrow_err: assert property (
		ce && acc_bad |=> acc_err && !acc_ack && $stable(ctrl))
		else $error("narrow access not refused");

	a_soft_pulse: assert property (
		ce && soft_clr |=> soft_reset_pulse && $stable(func)
			&& $stable(dev_addr))
		else $error("soft reset missing or disturbed selects");

	a_soft_clears: assert property (
		ce && soft_clr ##1 ce[*2] |-> tok_pass_pid == 4'h0
			&& !tok_pass)
		else $error("soft reset left machine state");

	a_rsvd_bit3: assert property (
		ce && wr_ctrl |=> !ctrl[3]
			&& ctrl[7] == $past(acc_wdata[7]))
		else $error("control write mishandled");

	a_addr_match: assert property (
		ce && tok_pass && !$past(tok_pid[3:0] == PID_SOF)
			|-> $past(tok_addr) == dev_addr)
		else $error("token passed with wrong address");

	a_no_proc: assert property (
		ce && tok_valid && !token_processing_enable |=> !tok_pass)
		else $error("token passed while processing off");

	a_func_write: assert property (
		ce && wr_func |=> termselect == $past(acc_wdata[1])
			&& xcvrselect == $past(acc_wdata[0]))
		else $error("select write not applied");

	a_unmapped_zero: assert property (
		ce && rd_ok && !hit_aux && !hit_ctrl && !hit_addr && !hit_func
			&& !hit_otgf && !hit_pid && !hit_endp
			|=> acc_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_ro_ignored: assert property (
		ce && wr_ok && (hit_otgf || hit_pid || hit_endp)
			|=> $stable(ctrl) && $stable(func) && $stable(dev_addr))
		else $error("read-only write changed state");

	c_soft_reset: cover property (ce && soft_clr);
	c_token_pass: cover property (tok_pass);
	c_sof_token:  cover property (tok_pass && frame_start_as_token);
	c_narrow:     cover property (acc_err);

endmodule : usb_ifm_ctrl

// ### verif/usb_host_model.sv
/*
 * Behavioural far side of the token port: transceiver and upstream host
 * presenting received tokens, one strobe per call of send.
 * Assumes a free-running clk and a caller running procedural code.
 */
module usb_host_model (
	input  wire logic  clk,
	input  wire logic  pass_in,
	output logic       tok_valid,
	output logic [7:0] tok_pid,
	output logic [6:0] tok_addr,
	output logic [3:0] tok_endp
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Idle state
	// ************************************************************
	initial begin
		tok_valid = 1'b0;
		tok_pid   = 8'h00;
		tok_addr  = 7'h55;
		tok_endp  = 4'h0;
	end

	// One strobe, then fields inverted so stale data can never match
	task automatic send(input logic [7:0] pid, input logic [6:0] addr,
		input logic [3:0] endp, output logic seen);
		@(negedge clk);
		tok_valid = 1'b1;
		tok_pid   = pid;
		tok_addr  = addr;
		tok_endp  = endp;
		@(negedge clk);
		tok_valid = 1'b0;
		tok_pid   = ~pid;
		tok_addr  = ~addr;
		tok_endp  = ~endp;
		seen      = pass_in;
	endtask : send
endmodule : usb_host_model

// ### verif/usb_interface_machine_control_bench.sv
/*
 * Self-checking bench of the USB interface machine control block.
 * Assumes the design package and the token host model are compiled first.
 */
module usb_interface_machine_control_bench;
	import usb_ifm_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Signals
	// ************************************************************
	logic        clk = 1'b0;
	logic        rst_n, ce, acc_valid, acc_write, acc_word;
	logic [7:0]  acc_periph, acc_addr;
	logic [31:0] acc_wdata, acc_rdata, r_data;
	logic        acc_ack, acc_err, r_ack, r_err, r_pulse;
	logic [5:0]  otg_flags;
	logic        tok_valid, tok_pass, soft_reset_pulse;
	logic [7:0]  tok_pid;
	logic [6:0]  tok_addr;
	logic [3:0]  tok_endp, tok_pass_pid, tok_pass_endp;
	logic        proc_en, chk_en, line_en, tim_en, pwr_en, sof_en, ev_en;
	logic [2:0]  opmode;
	logic        opmode_enable, termselect, xcvrselect;
	int          bad_count = 0;
	int          n_checks = 0;
	wire  [7:0]  en_vec = {ev_en, sof_en, pwr_en, tim_en, 1'b0, line_en,
		chk_en, proc_en};

	always #2 clk = ~clk;

	usb_ifm_ctrl dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.acc_valid(acc_valid), .acc_write(acc_write),
		.acc_periph(acc_periph), .acc_word(acc_word), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_err(acc_err),
		.acc_rdata(acc_rdata), .otg_flags(otg_flags),
		.tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
		.tok_endp(tok_endp), .tok_pass(tok_pass),
		.tok_pass_pid(tok_pass_pid), .tok_pass_endp(tok_pass_endp),
		.soft_reset_pulse(soft_reset_pulse),
		.token_processing_enable(proc_en), .token_check_enable(chk_en),
		.linestate_decoder_enable(line_en), .timing_mode_enable(tim_en),
		.power_signalling_enable(pwr_en), .frame_start_as_token(sof_en),
		.event_acknowledge_mode(ev_en), .opmode(opmode),
		.opmode_enable(opmode_enable), .termselect(termselect),
		.xcvrselect(xcvrselect));

	usb_host_model host (.clk(clk), .pass_in(tok_pass),
		.tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
		.tok_endp(tok_endp));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One access; answer is captured the cycle after it is taken
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic word, input logic [7:0] per);
		@(negedge clk);
		acc_valid  = 1'b1;
		acc_write  = wr;
		acc_addr   = a;
		acc_wdata  = d;
		acc_word   = word;
		acc_periph = per;
		@(negedge clk);
		acc_valid  = 1'b0;
		acc_wdata  = ~d;
		r_ack      = acc_ack;
		r_err      = acc_err;
		r_data     = acc_rdata;
		r_pulse    = soft_reset_pulse;
	endtask : acc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 1'b1, PERIPH_NUMBER);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0000_0000, 1'b1, PERIPH_NUMBER);
		chk({31'h0, r_ack}, 32'h0000_0001);
		chk(r_data, exp);
	endtask : rdchk

	// Token through the host model; pass compared, captured fields too when a pass is expected
	task automatic tok(input logic [7:0] p, input logic [6:0] a,
		input logic [3:0] e, input logic exp);
		logic seen;
		host.send(p, a, e, seen);
		chk({31'h0, seen}, {31'h0, exp});
		if (exp) begin
			chk({24'h0, tok_pass_pid, tok_pass_endp}, {24'h0, p[3:0], e});
		end
	endtask : tok

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		rdchk(OFS_IFM_CONTROL, 32'h0000_0000);
		rdchk(OFS_DEVICE_ADDRESS, 32'h0000_0000);
		rdchk(OFS_FUNC_CONTROL, 32'h0000_0007);
		chk({27'h0, opmode, termselect, xcvrselect}, 32'h7);
		$display("test reset done");
	endtask : t_reset

	// Walking one through control bits 7:0, reserved bit 3 included; upper bits written as ones
	task automatic t_ctrl;
		for (int i = 0; i < 8; i++) begin
			wr(OFS_IFM_CONTROL, 32'hFFFF_FF00 | (32'h1 << i));
			chk({24'h0, en_vec}, (32'h1 << i) & 32'hF7);
			rdchk(OFS_IFM_CONTROL, (32'h1 << i) & 32'hF7);
		end
		$display("test control done");
	endtask : t_ctrl

	task automatic t_func;
		logic [4:0] v[4] = '{5'h00, 5'h02, 5'h1F, 5'h11};
		for (int i = 0; i < 4; i++) begin
			wr(OFS_FUNC_CONTROL, {27'h7FF_FFFF, v[i]});
			chk({27'h0, opmode, termselect, xcvrselect}, {27'h0, v[i]});
			chk({31'h0, opmode_enable}, {31'h0, |v[i][4:2]});
			rdchk(OFS_FUNC_CONTROL, {27'h0, v[i]});
		end
		$display("test function done");
	endtask : t_func

	task automatic t_map;
		wr(OFS_OTG_FLAGS, 32'hFFFF_FFFF);
		rdchk(OFS_OTG_FLAGS, 32'h0000_002D);
		wr(OFS_RX_PID, 32'hFFFF_FFFF);
		rdchk(OFS_RX_PID, 32'h0000_0000);
		wr(8'h44, 32'hFFFF_FFFF);
		chk({31'h0, r_ack}, 32'h1);
		rdchk(8'h44, 32'h0000_0000);
		wr(OFS_OTG_CONTROL, 32'hA5A5_5A5A);
		rdchk(OFS_OTG_CONTROL, 32'hA5A5_5A5A);
		acc(1'b1, OFS_DEVICE_ADDRESS, 32'h7F, 1'b0, PERIPH_NUMBER);
		chk({30'h0, r_ack, r_err}, 32'h1);
		acc(1'b1, OFS_DEVICE_ADDRESS, 32'h7F, 1'b1, 8'h02);
		chk({30'h0, r_ack, r_err}, 32'h0);
		rdchk(OFS_DEVICE_ADDRESS, 32'h0000_0000);
		wr(OFS_DEVICE_ADDRESS, 32'hFFFF_FFFF);
		rdchk(OFS_DEVICE_ADDRESS, 32'h0000_007F);
		$display("test map done");
	endtask : t_map

	task automatic t_token;
		wr(OFS_DEVICE_ADDRESS, 32'h0);
		wr(OFS_IFM_CONTROL, 32'h0);
		tok(8'hD2, 7'h00, 4'h3, 1'b0);
		wr(OFS_IFM_CONTROL, 32'h1);
		tok(8'hD2, 7'h00, 4'h3, 1'b1);
		wr(OFS_DEVICE_ADDRESS, 32'h2A);
		tok(8'hD2, 7'h00, 4'h3, 1'b0);
		tok(8'h12, 7'h2A, 4'h9, 1'b1);
		wr(OFS_IFM_CONTROL, 32'h3);
		tok(8'h12, 7'h2A, 4'h9, 1'b0);
		tok(8'hE1, 7'h2A, 4'hC, 1'b1);
		tok(8'hA5, 7'h2A, 4'h0, 1'b0);
		wr(OFS_IFM_CONTROL, 32'h43);
		tok(8'hA5, 7'h11, 4'h6, 1'b1);
		wr(OFS_SOFT_RESET, 32'h1234_5678);
		chk({31'h0, r_pulse}, 32'h1);
		chk({24'h0, tok_pass_pid, tok_pass_endp}, 32'h0);
		rdchk(OFS_IFM_CONTROL, 32'h0000_0043);
		rdchk(OFS_DEVICE_ADDRESS, 32'h0000_002A);
		$display("test token done");
	endtask : t_token

	// ************************************************************
	// Closing, watchdog and main sequence
	// ************************************************************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	// About 50 accesses and 8 tokens of two cycles each; ample margin
	initial begin
		#(4 * 5000);
		bad_count++;
		end_sim();
	end

	initial begin
		rst_n      = 1'b0;
		ce         = 1'b1;
		acc_valid  = 1'b0;
		acc_write  = 1'b0;
		acc_word   = 1'b1;
		acc_periph = 8'h00;
		acc_addr   = 8'h00;
		acc_wdata  = 32'h0000_0000;
		otg_flags  = 6'h2D;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_ctrl();
		t_func();
		t_map();
		t_token();
		end_sim();
	end
endmodule : usb_interface_machine_control_bench
